// >>> inc/flpc_pkg.sv
// Package: register map, field positions, reset values and timing for the fault/PWM block
package flpc_pkg;
  // Register offsets (byte addresses, one 32-bit word each)
  localparam logic [7:0] ADDR_GLOBAL_STATUS = 8'h00;
  localparam logic [7:0] ADDR_FAULT0 = 8'h04;
  localparam logic [7:0] ADDR_FAULT1 = 8'h08;
  localparam logic [7:0] ADDR_DUTY0 = 8'h0c;
  localparam logic [7:0] ADDR_DUTY1 = 8'h10;
  localparam logic [7:0] ADDR_OCFG0 = 8'h14;
  localparam logic [7:0] ADDR_OCFG1 = 8'h18;
  localparam logic [7:0] ADDR_CTRL = 8'h1c;
  localparam logic [7:0] ADDR_MODE = 8'h20;
  // Channel fault register bits
  localparam int FB_OC = 0;
  localparam int FB_SC = 1;
  localparam int FB_OT = 2;
  localparam int FB_OS = 3;
  localparam int FB_OLON = 4;
  localparam int FB_OLOFF = 5;
  localparam int FB_LATCHED = 6;
  localparam int NFB = 6;
  // Global status bits
  localparam int GB_UV = 0;
  localparam int GB_OV = 1;
  localparam int GB_CLKF = 2;
  localparam int GB_POR = 3;
  localparam int NGB = 3;
  // Duty register: D8 on bit, D7..D0 duty
  localparam int DUTY_ON = 8;
  // Output config: D6 clock select, D7 prescaler
  localparam int OC_CLK_INT = 6;
  localparam int OC_PRESC = 7;
  // Control register bits
  localparam int CB_PWM_EN0 = 0;
  localparam int CB_PWM_EN1 = 1;
  localparam int CB_DIR_DIS0 = 2;
  localparam int CB_DIR_DIS1 = 3;
  localparam int CB_RETRY_EN0 = 4;
  localparam int CB_RETRY_EN1 = 5;
  localparam int CB_OV_EN = 6;
  localparam int CB_CLKF_EN = 7;
  localparam int CB_OS_EN = 8;
  localparam int CB_OLON_EN = 9;
  localparam int CB_OLOFF_EN = 10;
  localparam int CB_RETRY_CLR0 = 11;
  localparam int CB_RETRY_CLR1 = 12;
  localparam logic [12:0] CTRL_RESET = 13'h00c0;
  localparam int CTRL_W = 13;
  // Timing
  localparam int CLK_HZ = 25_000_000;
  localparam int RETRY_PERIOD_US = 10_000;
  localparam int RETRY_CYCLES = RETRY_PERIOD_US * (CLK_HZ / 1_000_000);
  localparam int RETRY_MAX_DEF = 15;
  localparam logic [8:0] PWM_DIV_BASE = 9'h0ff;
  localparam logic [8:0] PWM_DIV_DOUBLE = 9'h1ff;
  // Mode codes
  typedef enum logic [2:0] {
    FLPC_NORMAL = 3'b001,
    FLPC_FAILSAFE = 3'b010,
    FLPC_FAULT = 3'b100
  } flpc_mode_e;
  // Per-channel detector inputs
  typedef struct packed {
    logic overcurrent;
    logic severe_short;
    logic overtemperature;
    logic out_short;
    logic open_on;
    logic open_off;
  } flpc_det_s;
endpackage

// >>> src/flpc_top.sv
// Fault mode, latchable fault, delatch control and PWM modulator of a dual high-side switch
`timescale 1ns/1ns
module flpc_top
  import flpc_pkg::*;
#(
  parameter int RETRY_CNT = RETRY_CYCLES,
  parameter int RETRY_MAX = RETRY_MAX_DEF
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Mode inputs
  input wire logic wake_up,
  input wire logic fail_safe,
  input wire logic power_on,
  // Detectors
  input wire flpc_det_s [1:0] det,
  input wire logic undervoltage,
  input wire logic overvoltage,
  input wire logic clock_fail,
  // Direct inputs and activity
  input wire logic [1:0] in_pin,
  input wire logic [1:0] in_active,
  // Clock enables: internal oscillator tick, external PWM clock tick
  input wire logic int_tick,
  input wire logic ext_tick,
  // Outputs
  output logic fault_status_n,
  output logic [1:0] hs_on,
  output logic [2:0] mode
);
  initial begin
    if (RETRY_CNT < 1 || RETRY_MAX < 1 || RETRY_MAX > 15) $error("flpc_top: bad parameters");
  end

  logic [CTRL_W-1:0] ctrl;
  logic [8:0] duty_register [2];
  logic [7:0] output_config_register [2];
  logic [NFB-1:0] channel_fault_register [2];
  logic [NGB-1:0] global_status_register;
  logic por_flag;
  logic [1:0] latched;
  logic [1:0] retry_wait;
  logic [3:0] retry_num [2];
  logic [31:0] retry_tmr [2];
  logic [1:0] fc_q;
  logic [1:0] fc_low_seen;
  logic [8:0] pwm_cnt [2];
  logic [1:0] pwm_out;
  logic fail_safe_q;
  flpc_mode_e mode_q;

  // Bus decode
  wire wr = psel & penable & pwrite;
  wire rd = psel & penable & ~pwrite;
  wire hit = paddr inside {ADDR_GLOBAL_STATUS, ADDR_FAULT0, ADDR_FAULT1, ADDR_DUTY0,
                           ADDR_DUTY1, ADDR_OCFG0, ADDR_OCFG1, ADDR_CTRL, ADDR_MODE};
  wire regs_locked = fail_safe;
  assign pready = 1'b1;
  assign pslverr = psel & penable & (~hit | (regs_locked & paddr != ADDR_MODE));

  // Live fault terms
  wire [1:0] ch_oc = {det[1].overcurrent, det[0].overcurrent};
  wire [1:0] ch_sc = {det[1].severe_short, det[0].severe_short};
  wire [1:0] ch_ot = {det[1].overtemperature, det[0].overtemperature};
  wire [1:0] ch_os = {det[1].out_short, det[0].out_short} & {2{ctrl[CB_OS_EN]}};
  wire [1:0] ch_olon = {det[1].open_on, det[0].open_on} & {2{ctrl[CB_OLON_EN]}};
  wire [1:0] ch_oloff = {det[1].open_off, det[0].open_off} & {2{ctrl[CB_OLOFF_EN]}};
  wire ov_live = overvoltage & ctrl[CB_OV_EN];
  wire clkf_live = clock_fail & ctrl[CB_CLKF_EN];
  wire [1:0] latchable = ch_oc | ch_sc | ch_ot | {2{undervoltage}};
  wire [1:0] ch_fault_any = latchable | ch_os | ch_olon | ch_oloff;
  wire fault_term = |ch_fault_any | ov_live | clkf_live | |latched;
  wire [1:0] ch_off = latchable | {2{ov_live}} | latched | retry_wait;

  // Fault control and its high-low-high sequence
  wire [1:0] dir_dis = {ctrl[CB_DIR_DIS1], ctrl[CB_DIR_DIS0]};
  wire [1:0] on_bit = {duty_register[1][DUTY_ON], duty_register[0][DUTY_ON]};
  wire [1:0] fault_control = (in_active & ~dir_dis) | on_bit;
  wire [1:0] fc_rise = fault_control & ~fc_q;
  wire [1:0] retry_clr = {ctrl[CB_RETRY_CLR1], ctrl[CB_RETRY_CLR0]} &
                         {ctrl[CB_RETRY_EN1], ctrl[CB_RETRY_EN0]};
  wire [1:0] delatch_seq = (fc_rise & fc_low_seen) | retry_clr;
  wire fs_rise = fail_safe & ~fail_safe_q;
  wire fs_delatch = fs_rise & (mode_q == FLPC_FAULT);
  wire reg_reset = power_on | fs_delatch | fail_safe;

  // Read clear masks
  wire rd_f0 = rd & ~regs_locked & paddr == ADDR_FAULT0;
  wire rd_f1 = rd & ~regs_locked & paddr == ADDR_FAULT1;
  wire rd_gs = rd & ~regs_locked & paddr == ADDR_GLOBAL_STATUS;
  wire [NFB-1:0] live_f [2];
  assign live_f[0] = {ch_oloff[0], ch_olon[0], ch_os[0], ch_ot[0], ch_sc[0], ch_oc[0]};
  assign live_f[1] = {ch_oloff[1], ch_olon[1], ch_os[1], ch_ot[1], ch_sc[1], ch_oc[1]};
  wire [NGB-1:0] live_g = {clkf_live, ov_live, undervoltage};

  // Mode decode
  flpc_mode_e next_mode;
  always_comb begin
    if (wake_up && fault_term) begin
      next_mode = FLPC_FAULT;
    end else if (fail_safe) begin
      next_mode = FLPC_FAILSAFE;
    end else begin
      next_mode = FLPC_NORMAL;
    end
  end
  assign mode = mode_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= FLPC_NORMAL;
      fail_safe_q <= 1'b0;
      fc_q <= 2'b00;
    end else begin
      mode_q <= next_mode;
      fail_safe_q <= fail_safe;
      fc_q <= fault_control;
    end
  end

  // Control and global status registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
    end else if (reg_reset) begin
      ctrl <= CTRL_RESET;
    end else if (wr && paddr == ADDR_CTRL) begin
      ctrl <= pwdata[CTRL_W-1:0];
    end else begin
      ctrl[CB_RETRY_CLR1:CB_RETRY_CLR0] <= 2'b00;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_flag <= 1'b0;
      global_status_register <= '0;
    end else if (power_on) begin
      por_flag <= 1'b1;
      global_status_register <= '0;
    end else begin
      if (rd_gs) begin
        por_flag <= 1'b0;
      end
      // Set wins over clear; read clears only once cause is gone
      global_status_register <= live_g |
        (global_status_register & ~({NGB{rd_gs & ~fail_safe}} & ~live_g));
    end
  end

  genvar c;
  for (c = 0; c < 2; c++) begin : g_ch
    wire own_delatch = delatch_seq[c] & ~latchable[c];
    wire retry_fire = retry_wait[c] && retry_tmr[c] == 32'(RETRY_CNT - 1);
    wire turn_on = retry_fire | own_delatch;
    wire exhausted = retry_num[c] == 4'(RETRY_MAX);
    wire rd_c = (c == 0) ? rd_f0 : rd_f1;
    wire [1:0] div_done = {pwm_cnt[c] == PWM_DIV_DOUBLE, pwm_cnt[c] == PWM_DIV_BASE};
    wire clk_int = output_config_register[c][OC_CLK_INT];
    wire presc = output_config_register[c][OC_PRESC] & ~clk_int;
    wire tick = clk_int ? int_tick : ext_tick;
    wire wrap = presc ? div_done[1] : div_done[0];
    wire [7:0] pos = presc ? pwm_cnt[c][8:1] : pwm_cnt[c][7:0];
    wire pwm_en = ctrl[CB_PWM_EN0 + c];

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        duty_register[c] <= '0;
        output_config_register[c] <= '0;
      end else if (reg_reset) begin
        duty_register[c] <= '0;
        output_config_register[c] <= '0;
      end else if (wr && paddr == (c == 0 ? ADDR_DUTY0 : ADDR_DUTY1)) begin
        duty_register[c] <= pwdata[8:0];
      end else if (wr && paddr == (c == 0 ? ADDR_OCFG0 : ADDR_OCFG1)) begin
        output_config_register[c] <= pwdata[7:0];
      end
    end

    // Fault bits: sticky, cleared by read only when cause gone, not latched and not waiting to retry
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        channel_fault_register[c] <= '0;
      end else if (power_on) begin
        channel_fault_register[c] <= '0;
      end else begin
        channel_fault_register[c] <= live_f[c] | (channel_fault_register[c] &
          ~({NFB{rd_c & ~latched[c] & ~retry_wait[c]}} & ~live_f[c]));
      end
    end

    // Auto-retry and latch
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        latched[c] <= 1'b0;
        retry_wait[c] <= 1'b0;
        retry_num[c] <= '0;
        retry_tmr[c] <= '0;
        fc_low_seen[c] <= 1'b0;
      end else if (power_on || fs_delatch) begin
        latched[c] <= 1'b0;
        retry_wait[c] <= 1'b0;
        retry_num[c] <= '0;
        retry_tmr[c] <= '0;
        fc_low_seen[c] <= 1'b0;
      end else begin
        if (!fault_control[c]) begin
          fc_low_seen[c] <= 1'b1;
        end else if (fc_rise[c]) begin
          fc_low_seen[c] <= 1'b0;
        end
        if (latched[c]) begin
          if (own_delatch) begin
            latched[c] <= 1'b0;
            retry_num[c] <= '0;
          end
        end else if (retry_wait[c]) begin
          retry_tmr[c] <= retry_tmr[c] + 32'd1;
          if (own_delatch) begin
            retry_wait[c] <= 1'b0;
            retry_num[c] <= '0;
            retry_tmr[c] <= '0;
          end else if (retry_fire) begin
            retry_tmr[c] <= '0;
            if (exhausted && latchable[c]) begin
              latched[c] <= 1'b1;
              retry_wait[c] <= 1'b0;
            end else if (!latchable[c]) begin
              retry_wait[c] <= 1'b0;
            end else begin
              retry_num[c] <= retry_num[c] + 4'd1;
            end
          end else if (!ctrl[CB_RETRY_EN0 + c] && !latchable[c] && fc_rise[c]) begin
            retry_wait[c] <= 1'b0;
          end
        end else if (latchable[c]) begin
          retry_wait[c] <= 1'b1;
          retry_tmr[c] <= '0;
        end
        if (!ctrl[CB_RETRY_EN0 + c] && retry_wait[c] && retry_fire) begin
          retry_tmr[c] <= retry_tmr[c];
        end
      end
    end

    // PWM modulator
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pwm_cnt[c] <= '0;
      end else if (!pwm_en || !on_bit[c]) begin
        pwm_cnt[c] <= '0;
      end else if (tick) begin
        pwm_cnt[c] <= wrap ? 9'h000 : pwm_cnt[c] + 9'h001;
      end
    end
    assign pwm_out[c] = duty_register[c][7:0] == 8'hff || pos <= duty_register[c][7:0];

    wire serial_on = on_bit[c] & (pwm_en ? pwm_out[c] : 1'b1);
    wire direct_on = in_pin[c] & (~dir_dis[c] | fail_safe);
    wire target = direct_on | (serial_on & ~fail_safe);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        hs_on[c] <= 1'b0;
      end else begin
        hs_on[c] <= target & ~ch_off[c] & wake_up;
      end
    end
  end

  // Fault status pin follows live faults and latched channels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_status_n <= 1'b1;
    end else if (power_on) begin
      fault_status_n <= 1'b1;
    end else begin
      fault_status_n <= ~fault_term;
    end
  end

  // Read data
  logic [31:0] next_prdata;
  always_comb begin
    next_prdata = 32'h0;
    unique case (paddr)
      ADDR_GLOBAL_STATUS: next_prdata = 32'({por_flag, global_status_register});
      ADDR_FAULT0: next_prdata = 32'({latched[0], channel_fault_register[0]});
      ADDR_FAULT1: next_prdata = 32'({latched[1], channel_fault_register[1]});
      ADDR_DUTY0: next_prdata = 32'(duty_register[0]);
      ADDR_DUTY1: next_prdata = 32'(duty_register[1]);
      ADDR_OCFG0: next_prdata = 32'(output_config_register[0]);
      ADDR_OCFG1: next_prdata = 32'(output_config_register[1]);
      ADDR_CTRL: next_prdata = 32'(ctrl);
      ADDR_MODE: next_prdata = 32'({retry_wait, hs_on, mode_q});
      default: next_prdata = 32'h0;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= (regs_locked && paddr != ADDR_MODE) ? 32'h0 : next_prdata;
    end
  end
endmodule

// >>> dv/flpc_top_sva.sv
// Port-level assertions for the fault latch and PWM block
`timescale 1ns/1ns
module flpc_top_sva
  import flpc_pkg::*;
#(
  parameter int RETRY_CNT = 20,
  parameter int RETRY_MAX = 2
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Mode and detectors
  input wire logic wake_up,
  input wire logic fail_safe,
  input wire logic power_on,
  input wire flpc_det_s [1:0] det,
  input wire logic undervoltage,
  input wire logic overvoltage,
  input wire logic clock_fail,
  // Outputs
  input wire logic fault_status_n,
  input wire logic [1:0] hs_on,
  input wire logic [2:0] mode
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_awake;
    wake_up && !power_on;
  endsequence
  sequence s_quiet;
    !undervoltage && !overvoltage && !clock_fail && det == '0;
  endsequence
  a_oc_pin_low: assert property (s_awake ##0 det[0].overcurrent |=> !fault_status_n)
    else $error("fault pin not low after overcurrent");
  a_oc_chan_off: assert property (det[0].overcurrent |=> !hs_on[0])
    else $error("channel 0 on during overcurrent");
  a_sc_chan_off: assert property (det[1].severe_short |=> !hs_on[1])
    else $error("channel 1 on during severe short");
  a_uv_both_off: assert property (undervoltage |=> hs_on == 2'b00)
    else $error("a channel on during undervoltage");
  a_ot_pin_low: assert property ($rose(det[1].overtemperature) ##0 s_awake |=> !fault_status_n)
    else $error("fault pin not low after overtemperature");
  a_fault_mode: assert property (s_awake ##0 (undervoltage || det[0].severe_short)
    |=> mode == FLPC_FAULT)
    else $error("mode is not fault");
  a_fs_locked: assert property (psel && penable && fail_safe && paddr != ADDR_MODE |-> pslverr)
    else $error("register access not refused in fail-safe");
  a_por_release: assert property (power_on ##0 s_quiet |=> fault_status_n)
    else $error("fault pin low after power-on");
  a_unmapped_err: assert property (psel && penable && paddr > ADDR_MODE |-> pslverr)
    else $error("unmapped access not refused");
  a_ready_high: assert property (pready)
    else $error("ready not high");
endmodule
bind flpc_top flpc_top_sva #(.RETRY_CNT(RETRY_CNT), .RETRY_MAX(RETRY_MAX)) u_sva (.pclk,
  .presetn, .psel, .penable, .paddr, .pready, .pslverr, .wake_up, .fail_safe, .power_on,
  .det, .undervoltage, .overvoltage, .clock_fail, .fault_status_n, .hs_on, .mode);

// >>> dv/flpc_mcu_model.sv
// Controller side: direct input pins and their activity tracking
`timescale 1ns/1ns
module flpc_mcu_model #(
  parameter int TIN = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Direct inputs
  output logic [1:0] in_pin,
  output logic [1:0] in_active
);
  int idle [2];
  initial in_pin = 2'b00;
  // Activity drops after TIN idle cycles
  always_ff @(posedge pclk or negedge presetn) begin
    for (int i = 0; i < 2; i++) begin
      if (!presetn) begin
        idle[i] <= TIN;
      end else begin
        idle[i] <= in_pin[i] ? 0 : (idle[i] < TIN ? idle[i] + 1 : TIN);
      end
    end
  end
  assign in_active[0] = idle[0] < TIN;
  assign in_active[1] = idle[1] < TIN;
  task automatic set_pin(input int ch, input logic v);
    @(posedge pclk);
    in_pin[ch] <= v;
  endtask
  // Low past the activity timeout, then high again
  task automatic delatch(input int ch);
    set_pin(ch, 1'b0);
    repeat (TIN + 2) @(posedge pclk);
    set_pin(ch, 1'b1);
  endtask
endmodule

// >>> dv/flpc_top_tb.sv
// Self-checking bench for the fault latch and PWM block
`timescale 1ns/1ns
module flpc_top_tb
  import flpc_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic wake_up, fail_safe, power_on, undervoltage, overvoltage, clock_fail;
  logic int_tick, ext_tick, fault_status_n;
  flpc_det_s [1:0] det;
  logic [1:0] in_pin, in_active, hs_on;
  logic [2:0] mode;
  int bad_count, samples_checked, ones;
  flpc_top #(.RETRY_CNT(20), .RETRY_MAX(2)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .wake_up, .fail_safe, .power_on, .det,
    .undervoltage, .overvoltage, .clock_fail, .in_pin, .in_active, .int_tick, .ext_tick,
    .fault_status_n, .hs_on, .mode);
  flpc_mcu_model mcu (.pclk, .presetn, .in_pin, .in_active);
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic test_done;
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 50 && pready !== 1'b1; i++) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdm(input logic [7:0] a, input logic [31:0] m, e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rd & m, e);
  endtask
  task automatic cnt_on(input int n);
    tk(600);
    ones = 0;
    repeat (n) begin
      @(posedge pclk);
      ones += hs_on[0];
    end
  endtask
  initial begin
    tk(20000);
    bad_count++;
    test_done();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {fail_safe, power_on, undervoltage, overvoltage, clock_fail, int_tick, ext_tick} = '0;
    det = '0;
    wake_up = 1'b1;
    presetn = 1'b0;
    tk(2);
    presetn <= 1'b1;
    chk("fsn_rst", fault_status_n, 1'b1);
    rdm(ADDR_CTRL, 32'hffffffff, 32'h0c0, "ctrl_rst");
    rdm(ADDR_MODE, 32'h7, 32'h1, "mode_rst");
    rdm(8'h40, 32'hffffffff, 32'h0, "unmapped");
    chk("unmapped_err", err, 1'b1);
    wr(ADDR_DUTY0, 32'h1ff);
    wr(ADDR_DUTY1, 32'h1ff);
    tk(1);
    chk("hs_serial", hs_on, 2'b11);
    wr(ADDR_CTRL, 32'h2f0);
    det[0].open_on <= 1'b1;
    tk(3);
    chk("fsn_ol", fault_status_n, 1'b0);
    chk("hs_ol", hs_on, 2'b11);
    det[0].open_on <= 1'b0;
    tk(3);
    rdm(ADDR_FAULT0, 32'h3f, 32'h10, "ol_kept");
    rdm(ADDR_FAULT0, 32'h3f, 32'h0, "ol_clr");
    overvoltage <= 1'b1;
    tk(3);
    chk("fsn_ov", fault_status_n, 1'b0);
    chk("hs_ov", hs_on, 2'b00);
    chk("mode_ov", mode, FLPC_FAULT);
    rdm(ADDR_GLOBAL_STATUS, 32'h7, 32'h2, "ov_live");
    overvoltage <= 1'b0;
    tk(3);
    chk("fsn_ov_gone", fault_status_n, 1'b1);
    rdm(ADDR_GLOBAL_STATUS, 32'h7, 32'h2, "ov_kept");
    rdm(ADDR_GLOBAL_STATUS, 32'h7, 32'h0, "ov_clr");
    det[0].overcurrent <= 1'b1;
    tk(2);
    det[0].overcurrent <= 1'b0;
    tk(60);
    chk("fsn_retry", fault_status_n, 1'b1);
    rdm(ADDR_FAULT0, 32'h1, 32'h1, "oc_kept");
    rdm(ADDR_FAULT0, 32'h1, 32'h0, "oc_clr");
    wr(ADDR_DUTY1, 32'h0);
    mcu.set_pin(1, 1'b1);
    tk(3);
    chk("hs_direct", hs_on[1], 1'b1);
    det[0].overcurrent <= 1'b1;
    det[1].overcurrent <= 1'b1;
    tk(300);
    det <= '0;
    tk(100);
    chk("fsn_latched", fault_status_n, 1'b0);
    rdm(ADDR_FAULT0, 32'h41, 32'h41, "latch_kept");
    rdm(ADDR_FAULT0, 32'h40, 32'h40, "latch_read");
    wr(ADDR_DUTY0, 32'h0ff);
    wr(ADDR_DUTY0, 32'h1ff);
    tk(10);
    chk("fsn_one_left", fault_status_n, 1'b0);
    chk("hs_ch0_back", hs_on[0], 1'b1);
    mcu.delatch(1);
    tk(10);
    chk("fsn_delatched", fault_status_n, 1'b1);
    chk("hs_ch1_back", hs_on[1], 1'b1);
    rdm(ADDR_FAULT0, 32'h40, 32'h0, "latch_clr");
    wr(ADDR_CTRL, 32'h0c1);
    wr(ADDR_OCFG0, 32'h40);
    wr(ADDR_DUTY0, 32'h13f);
    int_tick <= 1'b1;
    cnt_on(512);
    chk("pwm_int", ones, 32'd128);
    wr(ADDR_OCFG0, 32'h80);
    int_tick <= 1'b0;
    ext_tick <= 1'b1;
    cnt_on(1024);
    chk("pwm_presc", ones, 32'd256);
    wr(ADDR_DUTY0, 32'h1ff);
    cnt_on(512);
    chk("pwm_full", ones, 32'd512);
    wr(ADDR_DUTY0, 32'h0ff);
    cnt_on(512);
    chk("pwm_off", ones, 32'd0);
    fail_safe <= 1'b1;
    mcu.set_pin(0, 1'b1);
    tk(3);
    chk("mode_fs", mode, FLPC_FAILSAFE);
    chk("hs_fs", hs_on[0], 1'b1);
    rdm(ADDR_CTRL, 32'h0, 32'h0, "fs_read");
    chk("fs_err", err, 1'b1);
    overvoltage <= 1'b1;
    tk(3);
    chk("mode_fs_fault", mode, FLPC_FAULT);
    chk("fsn_fs_fault", fault_status_n, 1'b0);
    overvoltage <= 1'b0;
    tk(5);
    chk("mode_fs_back", mode, FLPC_FAILSAFE);
    chk("fsn_fs_back", fault_status_n, 1'b1);
    fail_safe <= 1'b0;
    tk(3);
    rdm(ADDR_CTRL, 32'hffffffff, 32'h0c0, "ctrl_fs_reset");
    det[1].overtemperature <= 1'b1;
    tk(2);
    det[1].overtemperature <= 1'b0;
    power_on <= 1'b1;
    tk(1);
    power_on <= 1'b0;
    tk(2);
    chk("fsn_por", fault_status_n, 1'b1);
    rdm(ADDR_FAULT1, 32'h4, 32'h0, "ot_por_clr");
    test_done();
  end
endmodule
